// [design/cif_regs.svh]
// Functional notes
// RULE1: Reset loads every configuration default and clears all input state to zero.
// RULE2: Nothing survives reset: counts, flags and outputs cleared, configuration set to its defaults.
// RULE3: Six filtered inputs in two count/direction/marker groups serve one to four channels.
// RULE4: Channel count comes from the counter-count field of configuration word 0.
// RULE5: One or two counters: existing channels take any mode and gate/preset.
// RULE6: Three counters: ch1, ch2 pulse/internal only; ch2 lacks gate/preset; ch3 absent.
// RULE7: Four counters: all pulse/internal; ch0, ch1 keep gate/preset, ch2, ch3 do not.
// RULE8: Each input picks its own filter: 5 ms, 500 us, 10 us or none.
// RULE9: 10 us filter blocks pulses up to 7.4 us, passes 25 us or wider.
// RULE10: 500 us filter blocks pulses up to 370 us, passes 1.25 ms or wider.
// RULE11: 5 ms filter blocks pulses up to 3.7 ms, passes 12.5 ms or wider.
// RULE12: Unfiltered path sees 250 ns pulses; counting rate still limited to 1 MHz.
// RULE13: Reported input state bits show filter inputs, untouched by inhibit or invert.
// RULE14: One indicator per input, lit while that input is on.
// RULE15: After power-up all indicators light briefly together before normal indication.
// RULE16: Filters are averaging low-pass; fast square waves may read as on.
// RULE17: Inputs are synchronised; filters are saturating up/down integrators with hysteresis.
// RULE18: Configurations not permitted by the counter count are rejected and flagged.
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH

`define CIF_ADDR_CFG      8'h00
`define CIF_ADDR_FSEL     8'h04
`define CIF_ADDR_MODE     8'h08
`define CIF_ADDR_STAT     8'h0C

`define CIF_RST_NSEL      2'h0
`define CIF_RST_FSEL      12'h000
`define CIF_RST_MODE      16'h1111

`define CIF_FSEL_NONE     2'h0
`define CIF_FSEL_SHORT    2'h1
`define CIF_FSEL_MID      2'h2
`define CIF_FSEL_LONG     2'h3

`define CIF_STAT_RAW_LSB  0
`define CIF_STAT_FLT_LSB  8
`define CIF_STAT_AV_LSB   16
`define CIF_STAT_ERR_BIT  24

`define CIF_RESP_OKAY     2'h0
`define CIF_RESP_SLVERR   2'h2

`define CIF_CLK_MHZ       125
`define CIF_FLT_SHORT_NS  10000
`define CIF_FLT_MID_NS    500000
`define CIF_FLT_LONG_NS   5000000
`define CIF_LAMP_MS       200

`endif

// [design/cif_pkg.sv]
`default_nettype none
package cif_pkg;

    typedef enum logic [2:0] {
        CIF_MODE_PULSE_EXT = 3'b000,
        CIF_MODE_PULSE_INT = 3'b001,
        CIF_MODE_UP_DOWN   = 3'b010,
        CIF_MODE_QUAD_X1   = 3'b011,
        CIF_MODE_QUAD_X2   = 3'b100,
        CIF_MODE_QUAD_X4   = 3'b101
    } cif_mode_e;

    typedef enum logic {
        CIF_PH_LAMP = 1'b0,
        CIF_PH_RUN  = 1'b1
    } cif_phase_e;

    typedef struct packed {
        logic       gate_en;
        logic [2:0] mode;
    } cif_chan_cfg_s;

    typedef struct packed {
        logic marker;
        logic direction;
        logic count;
    } cif_group_s;

    typedef struct packed {
        cif_group_s grp1;
        cif_group_s grp0;
    } cif_inputs_s;

endpackage : cif_pkg
`default_nettype wire

// [design/cif_top.sv]
// The address map and the AXI4-Lite slave port were decided locally.
`include "cif_regs.svh"
`default_nettype none
module cif_top #(
    parameter int FLT_SHORT_CYC = `CIF_FLT_SHORT_NS * `CIF_CLK_MHZ / 1000,
    parameter int FLT_MID_CYC   = `CIF_FLT_MID_NS * `CIF_CLK_MHZ / 1000,
    parameter int FLT_LONG_CYC  = `CIF_FLT_LONG_NS * `CIF_CLK_MHZ / 1000,
    parameter int LAMP_CYC      = `CIF_LAMP_MS * `CIF_CLK_MHZ * 1000
) (
    input  wire logic                     CLOCK,
    input  wire logic                     RST,
    input  wire logic                     CHAN0_COUNT_INPUT,
    input  wire logic                     CHAN0_DIRECTION_INPUT,
    input  wire logic                     CHAN0_MARKER_INPUT,
    input  wire logic                     CHAN1_COUNT_INPUT,
    input  wire logic                     CHAN1_DIRECTION_INPUT,
    input  wire logic                     CHAN1_MARKER_INPUT,
    input  wire logic [7:0]               AWADDR,
    input  wire logic                     AWVALID,
    output var  logic                     AWREADY,
    input  wire logic [31:0]              WDATA,
    input  wire logic [3:0]               WSTRB,
    input  wire logic                     WVALID,
    output var  logic                     WREADY,
    output var  logic [1:0]               BRESP,
    output var  logic                     BVALID,
    input  wire logic                     BREADY,
    input  wire logic [7:0]               ARADDR,
    input  wire logic                     ARVALID,
    output var  logic                     ARREADY,
    output var  logic [31:0]              RDATA,
    output var  logic [1:0]               RRESP,
    output var  logic                     RVALID,
    input  wire logic                     RREADY,
    output var  logic [5:0]               FILTERED_INPUTS,
    output var  logic [5:0]               INDICATORS,
    output var  logic [3:0]               CHAN_ENABLE,
    output var  cif_pkg::cif_chan_cfg_s [3:0] CHAN_CFG,
    output var  logic                     CFG_ERROR
);

    localparam int CNT_W  = $clog2(FLT_LONG_CYC + 1);
    localparam int LAMP_W = $clog2(LAMP_CYC + 1);

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic cfg_ok(input logic [1:0] nsel, input logic [15:0] mw);
        logic                   ok;
        cif_pkg::cif_chan_cfg_s c;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = mw[i*4 +: 4];
            if (2'(i) > nsel) begin
                if (c.gate_en) ok = 1'b0;                             // RULE5 RULE18
            end else begin
                if (c.mode > cif_pkg::CIF_MODE_QUAD_X4) ok = 1'b0;    // RULE18
                if (nsel == 2'h2 && i != 0 && c.mode != cif_pkg::CIF_MODE_PULSE_INT) begin
                    ok = 1'b0;                                        // RULE6
                end
                if (nsel == 2'h3 && c.mode != cif_pkg::CIF_MODE_PULSE_INT) begin
                    ok = 1'b0;                                        // RULE7
                end
                if (nsel >= 2'h2 && i >= 2 && c.gate_en) ok = 1'b0;   // RULE6 RULE7
            end
        end
        return ok;
    endfunction : cfg_ok

    function automatic logic [CNT_W-1:0] flt_limit(input logic [1:0] sel);
        case (sel)
            `CIF_FSEL_SHORT: return CNT_W'(FLT_SHORT_CYC);             // RULE9
            `CIF_FSEL_MID:   return CNT_W'(FLT_MID_CYC);               // RULE10
            `CIF_FSEL_LONG:  return CNT_W'(FLT_LONG_CYC);              // RULE11
            default:         return CNT_W'(1);
        endcase
    endfunction : flt_limit

    // Input synchronisers
    cif_pkg::cif_inputs_s pins;
    logic [5:0]           sync1_ff;
    logic [5:0]           raw_ff;

    assign pins.grp0 = {CHAN0_MARKER_INPUT, CHAN0_DIRECTION_INPUT, CHAN0_COUNT_INPUT};
    assign pins.grp1 = {CHAN1_MARKER_INPUT, CHAN1_DIRECTION_INPUT, CHAN1_COUNT_INPUT};

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sync1_ff <= 6'h00;                                        // RULE1
            raw_ff   <= 6'h00;
        end else begin
            sync1_ff <= pins;                                         // RULE17
            raw_ff   <= sync1_ff;
        end
    end

    // Configuration registers
    logic [1:0]  nsel_ff;
    logic [11:0] fsel_ff;
    logic [15:0] mode_ff;
    logic        err_ff;
    logic [3:0]  chan_en_ff;

    // Per-input integrating filters
    logic [CNT_W-1:0] cnt_ff [6];
    logic [5:0]       flt_ff;

    for (genvar g = 0; g < 6; g++) begin : g_flt
        wire [1:0]       sel    = fsel_ff[2*g +: 2];                  // RULE8
        wire [CNT_W-1:0] lim    = flt_limit(sel);
        wire             bypass = (sel == `CIF_FSEL_NONE);
        wire             up     = raw_ff[g] & (cnt_ff[g] < lim);
        wire             dn     = ~raw_ff[g] & (cnt_ff[g] != '0);
        wire [CNT_W-1:0] clamp  = (cnt_ff[g] > lim) ? lim : cnt_ff[g];
        wire [CNT_W-1:0] nxt_cnt;
        wire             nxt_flt;

        assign nxt_cnt = up ? cnt_ff[g] + CNT_W'(1) :                 // RULE16 RULE17
                         dn ? cnt_ff[g] - CNT_W'(1) : clamp;
        assign nxt_flt = bypass ? raw_ff[g] :                         // RULE12
                         (nxt_cnt >= lim) ? 1'b1 :                    // RULE17
                         (nxt_cnt == '0) ? 1'b0 : flt_ff[g];

        always_ff @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                cnt_ff[g] <= '0;
                flt_ff[g] <= 1'b0;                                    // RULE2
            end else begin
                cnt_ff[g] <= nxt_cnt;
                flt_ff[g] <= nxt_flt;
            end
        end
    end

    // AXI4-Lite write channel
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [7:0] wa_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    logic       awready_ff;
    logic       wready_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;

    wire aw_hs    = AWVALID & awready_ff;
    wire w_hs     = WVALID & wready_ff;
    wire do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire [7:0] wa = {wa_ff[7:2], 2'b00};
    wire wr_cfg   = do_write & (wa == `CIF_ADDR_CFG);
    wire wr_fsel  = do_write & (wa == `CIF_ADDR_FSEL);
    wire wr_mode  = do_write & (wa == `CIF_ADDR_MODE);
    wire wr_stat  = do_write & (wa == `CIF_ADDR_STAT);
    wire wr_hit   = wr_cfg | wr_fsel | wr_mode | wr_stat;

    wire [31:0] m_cfg  = wmerge({30'h0, nsel_ff}, wd_ff, ws_ff);
    wire [31:0] m_fsel = wmerge({20'h0, fsel_ff}, wd_ff, ws_ff);
    wire [31:0] m_mode = wmerge({16'h0, mode_ff}, wd_ff, ws_ff);
    wire [1:0]  cand_nsel = wr_cfg ? m_cfg[1:0] : nsel_ff;             // RULE4
    wire [15:0] cand_mode = wr_mode ? m_mode[15:0] : mode_ff;
    wire        cfg_try   = wr_cfg | wr_mode;
    wire        cfg_good  = cfg_ok(cand_nsel, cand_mode);
    wire        cfg_bad   = cfg_try & ~cfg_good;                      // RULE18
    wire        err_clr   = wr_stat & ws_ff[3] & wd_ff[`CIF_STAT_ERR_BIT];

    wire nxt_aw_got = (aw_got_ff | aw_hs) & ~do_write;
    wire nxt_w_got  = (w_got_ff | w_hs) & ~do_write;
    wire nxt_bvalid = do_write | (bvalid_ff & ~BREADY);
    wire [1:0] nxt_bresp = do_write ?
                           ((wr_hit & ~cfg_bad) ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR) :
                           bresp_ff;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CIF_RESP_OKAY;
            wa_ff      <= 8'h00;
            wd_ff      <= 32'h0000_0000;
            ws_ff      <= 4'h0;
        end else begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            if (aw_hs) wa_ff <= AWADDR;
            if (w_hs) begin
                wd_ff <= WDATA;
                ws_ff <= WSTRB;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            nsel_ff    <= `CIF_RST_NSEL;                              // RULE1
            fsel_ff    <= `CIF_RST_FSEL;
            mode_ff    <= `CIF_RST_MODE;
            err_ff     <= 1'b0;                                       // RULE2
            chan_en_ff <= 4'h0;
        end else begin
            if (cfg_try & cfg_good) begin
                nsel_ff <= cand_nsel;                                 // RULE4
                mode_ff <= cand_mode;
            end
            if (wr_fsel) fsel_ff <= m_fsel[11:0];                     // RULE8
            err_ff     <= cfg_bad | (err_ff & ~err_clr);              // RULE18
            chan_en_ff <= 4'((5'h02 << nsel_ff) - 5'h01);             // RULE3 RULE5
        end
    end

    // AXI4-Lite read channel
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    wire [7:0]  ra    = {ARADDR[7:2], 2'b00};
    wire        ar_hs = ARVALID & arready_ff;
    wire [31:0] stat_word = ({26'h0, raw_ff} << `CIF_STAT_RAW_LSB) |   // RULE13
                            ({26'h0, flt_ff} << `CIF_STAT_FLT_LSB) |
                            ({28'h0, chan_en_ff} << `CIF_STAT_AV_LSB) |
                            ({31'h0, err_ff} << `CIF_STAT_ERR_BIT);
    wire        rd_hit = (ra == `CIF_ADDR_CFG) | (ra == `CIF_ADDR_FSEL) |
                         (ra == `CIF_ADDR_MODE) | (ra == `CIF_ADDR_STAT);
    wire [31:0] rd_mux = (ra == `CIF_ADDR_CFG)  ? {30'h0, nsel_ff} :
                         (ra == `CIF_ADDR_FSEL) ? {20'h0, fsel_ff} :
                         (ra == `CIF_ADDR_MODE) ? {16'h0, mode_ff} :
                         (ra == `CIF_ADDR_STAT) ? stat_word : 32'h0000_0000;
    wire        nxt_rvalid = ar_hs | (rvalid_ff & ~RREADY);

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `CIF_RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_hs) begin
                rdata_ff <= rd_mux;
                rresp_ff <= rd_hit ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR;
            end
        end
    end

    // Power-up lamp test, then live indication
    cif_pkg::cif_phase_e phase_ff;
    cif_pkg::cif_phase_e nxt_phase;
    logic [LAMP_W-1:0]   lamp_cnt_ff;
    logic [5:0]          ind_ff;

    wire lamp_done = (lamp_cnt_ff == LAMP_W'(LAMP_CYC - 1));

    always_comb begin
        case (phase_ff)
            cif_pkg::CIF_PH_LAMP: nxt_phase = lamp_done ? cif_pkg::CIF_PH_RUN :
                                                          cif_pkg::CIF_PH_LAMP;
            cif_pkg::CIF_PH_RUN:  nxt_phase = cif_pkg::CIF_PH_RUN;
            default:              nxt_phase = cif_pkg::CIF_PH_LAMP;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            phase_ff    <= cif_pkg::CIF_PH_LAMP;
            lamp_cnt_ff <= '0;
            ind_ff      <= 6'h00;                                     // RULE2
        end else begin
            phase_ff    <= nxt_phase;
            if (phase_ff == cif_pkg::CIF_PH_LAMP) lamp_cnt_ff <= lamp_cnt_ff + LAMP_W'(1);
            ind_ff      <= (phase_ff == cif_pkg::CIF_PH_LAMP) ? 6'h3F : // RULE15
                           raw_ff;                                    // RULE14
        end
    end

    assign AWREADY         = awready_ff;
    assign WREADY          = wready_ff;
    assign BVALID          = bvalid_ff;
    assign BRESP           = bresp_ff;
    assign ARREADY         = arready_ff;
    assign RVALID          = rvalid_ff;
    assign RDATA           = rdata_ff;
    assign RRESP           = rresp_ff;
    assign FILTERED_INPUTS = flt_ff;
    assign INDICATORS      = ind_ff;
    assign CHAN_ENABLE     = chan_en_ff;
    assign CHAN_CFG        = mode_ff;
    assign CFG_ERROR       = err_ff;

endmodule : cif_top
`default_nettype wire

// [sim/cif_top_monitor.sv]
`default_nettype none
module cif_top_monitor #(
    parameter int LAMP_CYC = 8
) (
    input wire logic       CLOCK,
    input wire logic       RST,
    input wire logic       CHAN0_COUNT_INPUT,
    input wire logic       CHAN0_DIRECTION_INPUT,
    input wire logic       CHAN0_MARKER_INPUT,
    input wire logic       CHAN1_COUNT_INPUT,
    input wire logic       CHAN1_DIRECTION_INPUT,
    input wire logic       CHAN1_MARKER_INPUT,
    input wire logic       AWVALID,
    input wire logic       AWREADY,
    input wire logic       WVALID,
    input wire logic       WREADY,
    input wire logic [1:0] BRESP,
    input wire logic       BVALID,
    input wire logic       BREADY,
    input wire logic [5:0] INDICATORS,
    input wire logic [3:0] CHAN_ENABLE,
    input wire cif_pkg::cif_chan_cfg_s [3:0] CHAN_CFG,
    input wire logic       CFG_ERROR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    int         lamp_cnt_ff;
    int         nxt_lamp_cnt;
    wire logic [5:0] pins = {CHAN1_MARKER_INPUT, CHAN1_DIRECTION_INPUT, CHAN1_COUNT_INPUT,
                             CHAN0_MARKER_INPUT, CHAN0_DIRECTION_INPUT, CHAN0_COUNT_INPUT};
    wire logic [3:0] gates = {CHAN_CFG[3].gate_en, CHAN_CFG[2].gate_en,
                              CHAN_CFG[1].gate_en, CHAN_CFG[0].gate_en};
    // Cycles since reset, saturating once the lamp test is surely over
    assign nxt_lamp_cnt = (lamp_cnt_ff < LAMP_CYC + 4) ? lamp_cnt_ff + 1 : lamp_cnt_ff;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) lamp_cnt_ff <= 0;
        else lamp_cnt_ff <= nxt_lamp_cnt;
    end
    a_reset_clear: assert property ($fell(RST) |-> INDICATORS == 6'h00
        && !CFG_ERROR && CHAN_ENABLE == 4'h0 && CHAN_CFG == 16'h1111)
        else $error("Outputs not at reset values");
    a_lamp_test: assert property ($fell(RST) |=> (INDICATORS == 6'h3F) [*4])
        else $error("Lamp test missing");
    a_ind_follow: assert property (lamp_cnt_ff >= LAMP_CYC + 4
        |-> INDICATORS == $past(pins, 3)) else $error("Indicators not following inputs");
    a_enable_legal: assert property (!$past(RST)
        |-> CHAN_ENABLE inside {4'h1, 4'h3, 4'h7, 4'hF}) else $error("Bad channel set");
    a_absent_gate: assert property ((gates & ~CHAN_ENABLE) == 4'h0)
        else $error("Gate on absent channel");
    a_three_limits: assert property (CHAN_ENABLE == 4'h7
        |-> CHAN_CFG[1].mode == 3'h1 && CHAN_CFG[2] == 4'h1) else $error("Three channel limits");
    a_four_limits: assert property (CHAN_ENABLE == 4'hF
        |-> CHAN_CFG[3:2] == 8'h11 && CHAN_CFG[1].mode == 3'h1 && CHAN_CFG[0].mode == 3'h1)
        else $error("Four channel limits");
    a_error_answer: assert property ($rose(CFG_ERROR) |-> BVALID && BRESP == 2'h2)
        else $error("Config error without slave error");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("No write response");
    a_bvalid_once: assert property (BVALID && BREADY |=> !BVALID)
        else $error("Write response repeated");
    c_four: cover property (CHAN_ENABLE == 4'hF);
    c_reject: cover property ($rose(CFG_ERROR));
    c_release: cover property ($fell(RST));
endmodule : cif_top_monitor
bind cif_top cif_top_monitor #(.LAMP_CYC(LAMP_CYC)) cif_top_monitor_i (
    .CLOCK(CLOCK), .RST(RST), .CHAN0_COUNT_INPUT(CHAN0_COUNT_INPUT),
    .CHAN0_DIRECTION_INPUT(CHAN0_DIRECTION_INPUT), .CHAN0_MARKER_INPUT(CHAN0_MARKER_INPUT),
    .CHAN1_COUNT_INPUT(CHAN1_COUNT_INPUT), .CHAN1_DIRECTION_INPUT(CHAN1_DIRECTION_INPUT),
    .CHAN1_MARKER_INPUT(CHAN1_MARKER_INPUT), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .INDICATORS(INDICATORS), .CHAN_ENABLE(CHAN_ENABLE), .CHAN_CFG(CHAN_CFG),
    .CFG_ERROR(CFG_ERROR));
`default_nettype wire

// [sim/cif_field_model.sv]
`default_nettype none
module cif_field_model (
    input wire logic        clock,
    input wire logic [5:0]  base,
    input wire logic        go,
    input wire logic [2:0]  idx,
    input wire logic [15:0] width,
    output var logic [5:0]  pins
);
    timeunit 1ns;
    timeprecision 1ps;
    int left_ff = 0;
    // Sensor pulse: one input flipped from its idle level for width cycles
    always @(posedge clock) begin
        if (go) left_ff <= width;
        else if (left_ff > 0) left_ff <= left_ff - 1;
    end
    assign pins = (left_ff > 0) ? base ^ (6'h01 << idx) : base;
endmodule : cif_field_model
`default_nettype wire

// [sim/cif_top_bench.sv]
`default_nettype none
module cif_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LMT[4] = '{0, 10, 20, 40};
    // Config writes: {address, data, slave error expected}
    localparam logic [24:0] CFG_TAB[10] = '{
        {8'h00, 16'h0001, 1'b0}, {8'h08, 16'h00A5, 1'b0}, {8'h00, 16'h0002, 1'b1},
        {8'h08, 16'h0195, 1'b0}, {8'h00, 16'h0002, 1'b0}, {8'h08, 16'h0995, 1'b1},
        {8'h00, 16'h0003, 1'b1}, {8'h08, 16'h1199, 1'b0}, {8'h00, 16'h0003, 1'b0},
        {8'h08, 16'h9199, 1'b1}};
    logic        clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, go = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, cfg_error;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h00017D89;
    logic [3:0]  wstrb = 0, chan_enable;
    logic [1:0]  bresp, rresp;
    logic [5:0]  base = 0, pins, filtered, indicators;
    logic [2:0]  idx = 0;
    logic [15:0] width = 0;
    cif_pkg::cif_chan_cfg_s [3:0] chan_cfg;
    int          fails = 0, tests_run = 0;
    cif_top #(.FLT_SHORT_CYC(LMT[1]), .FLT_MID_CYC(LMT[2]), .FLT_LONG_CYC(LMT[3]),
        .LAMP_CYC(8)) cif_top_i (
        .CLOCK(clock), .RST(rst), .CHAN0_COUNT_INPUT(pins[0]), .CHAN0_DIRECTION_INPUT(pins[1]),
        .CHAN0_MARKER_INPUT(pins[2]), .CHAN1_COUNT_INPUT(pins[3]),
        .CHAN1_DIRECTION_INPUT(pins[4]), .CHAN1_MARKER_INPUT(pins[5]), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .FILTERED_INPUTS(filtered), .INDICATORS(indicators),
        .CHAN_ENABLE(chan_enable), .CHAN_CFG(chan_cfg), .CFG_ERROR(cfg_error));
    cif_field_model cif_field_model_i (.clock(clock), .base(base), .go(go), .idx(idx),
        .width(width), .pins(pins));
    initial forever #4 clock = ~clock;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [3:0] en_of(input logic [1:0] sel);
        return 4'hF >> (2'h3 - sel);
    endfunction : en_of
    // Blocked width scaled from 7.4 of 10, passed width from 25 of 10
    function automatic int pulse_w(input int s, input logic pass);
        return pass ? (s == 0 ? 2 : LMT[s] * 5 / 2) : LMT[s] * 74 / 100;
    endfunction : pulse_w
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 100) fails++;
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
        int n;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk(what, exp, rdata);
        chk("read resp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        if (n == 100) fails++;
    endtask : rchk
    task automatic pulse(input int i, input int s, input logic pass);
        logic seen;
        width <= 16'(pulse_w(s, pass));
        idx <= 3'(i);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        seen = 1'b0;
        repeat (200) begin
            @(posedge clock);
            seen = seen | filtered[i];
        end
        chk("filtered pulse", {31'h0, pass}, {31'h0, seen});
    endtask : pulse
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        report_and_stop();
    end
    initial begin
        logic [1:0]  r;
        logic [31:0] fs;
        logic [1:0]  cfg_m;
        logic [15:0] mode_m;
        logic        err_m;
        int          i, s, k;
        cfg_m = 2'h0;
        mode_m = 16'h1111;
        err_m = 1'b0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("lamp", 32'h3F, {26'h0, indicators});
        rchk("cfg reset", 8'h00, 32'h0, 2'h0);
        rchk("fsel reset", 8'h04, 32'h0, 2'h0);
        rchk("mode reset", 8'h08, 32'h1111, 2'h0);
        rchk("stat reset", 8'h0C, 32'h0001_0000, 2'h0);
        rchk("unmapped", 8'h10, 32'h0, 2'h2);
        for (i = 0; i < 3; i++) begin
            base <= 6'(xs());
            repeat (5) @(posedge clock);
            chk("indicators", {26'h0, base}, {26'h0, indicators});
            rchk("input state", 8'h0C, {16'h0001, 2'h0, base, 2'h0, base}, 2'h0);
        end
        base <= 6'h00;
        for (i = 0; i < 10; i++) begin
            wr(CFG_TAB[i][24:17], {16'h0, CFG_TAB[i][16:1]}, 4'hF, r);
            chk("write resp", {30'h0, CFG_TAB[i][0], 1'b0}, {30'h0, r});
            if (!CFG_TAB[i][0] && CFG_TAB[i][24:17] == 8'h00) cfg_m = CFG_TAB[i][2:1];
            if (!CFG_TAB[i][0] && CFG_TAB[i][24:17] == 8'h08) mode_m = CFG_TAB[i][16:1];
            err_m = err_m | CFG_TAB[i][0];
            rchk("cfg", 8'h00, {30'h0, cfg_m}, 2'h0);
            rchk("mode", 8'h08, {16'h0, mode_m}, 2'h0);
            chk("enable", {28'h0, en_of(cfg_m)}, {28'h0, chan_enable});
            chk("cfg error", {31'h0, err_m}, {31'h0, cfg_error});
            chk("chan cfg", {16'h0, mode_m}, {16'h0, chan_cfg});
        end
        wr(8'h0C, 32'h0100_0000, 4'h7, r);
        chk("err kept", 32'h1, {31'h0, cfg_error});
        wr(8'h0C, 32'h0100_0000, 4'h8, r);
        chk("err clear", 32'h0, {31'h0, cfg_error});
        wr(8'h14, 32'h0, 4'hF, r);
        chk("unmapped write", 32'h2, {30'h0, r});
        for (k = 0; k < 14; k++) begin
            i = (k < 8) ? k % 6 : xs() % 6;
            fs = (k < 8) ? (k / 2) << (2 * i) : xs() & 32'hFFF;
            s = (fs >> (2 * i)) & 3;
            wr(8'h04, fs, 4'hF, r);
            rchk("fsel", 8'h04, fs, 2'h0);
            pulse(i, s, k[0] || s == 0);
        end
        // Square wave of short pulses, each narrow enough to block alone
        wr(8'h04, 32'h1, 4'hF, r);
        for (k = 0; k < 40; k++) begin
            base <= {5'h00, k[1:0] != 2'h3};
            @(posedge clock);
        end
        repeat (3) @(posedge clock);
        chk("square wave", 32'h1, {31'h0, filtered[0]});
        wr(8'h08, 32'h1196, 4'hF, r);
        chk("bad mode", 32'h1, {31'h0, cfg_error});
        @(posedge clock);
        rst <= 1'b1;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rchk("mode cleared", 8'h08, 32'h1111, 2'h0);
        rchk("cfg cleared", 8'h00, 32'h0, 2'h0);
        chk("err cleared", 32'h0, {31'h0, cfg_error});
        chk("enable cleared", 32'h1, {28'h0, chan_enable});
        report_and_stop();
    end
endmodule : cif_top_bench
`default_nettype wire
